// [hw/pwm_brake_defines.svh]
`ifndef PWM_BRAKE_DEFINES_SVH
`define PWM_BRAKE_DEFINES_SVH

// Byte offsets on the Wishbone bus (register index times four)
`define IRQ_CONTROL_IDX 8'hb7
`define OUTPUT_POLARITY_IDX 8'hd6
`define BRAKE_CONTROL_DATA_IDX 8'hd7
`define PWM_CONTROL_IDX 8'he0
`define IRQ_CONTROL_ADDR 10'h2dc
`define OUTPUT_POLARITY_ADDR 10'h358
`define BRAKE_CONTROL_DATA_ADDR 10'h35c
`define PWM_CONTROL_ADDR 10'h380
`define MASK_ENABLE_ADDR 10'h384
`define MASK_LEVEL_ADDR 10'h388
`define BRAKE_STATUS_ADDR 10'h38c

// Field positions
`define BRAKE_FLAG_BIT 7
`define BRAKE_EDGE_SELECT_BIT 6
`define IRQ_TYPE_LSB 4
`define IRQ_CHANNEL_MSB 2
`define PWM_RUN_BIT 0
`define BRAKE_INPUT_ENABLE_BIT 1
`define CENTRE_ALIGNED_BIT 2

// Reset values
`define REG_RESET 8'h00

`endif

// [hw/pwm_brake_pkg.sv]
package pwm_brake_pkg;

    typedef enum logic [1:0] {
        irq_falling,
        irq_rising,
        irq_centre,
        irq_end
    } irq_type_t;

    typedef struct packed {
        logic [5:0] wave;
        logic period_centre;
        logic period_end;
    } pwm_events_t;

    typedef struct packed {
        logic [9:0] adr;
        logic [31:0] dat;
        logic we;
        logic [3:0] sel;
        logic cyc;
        logic stb;
    } wb_req_t;

endpackage

// [hw/brake_edge_detect.sv]
`timescale 1ns/1ps
`include "pwm_brake_defines.svh"

module brake_edge_detect (
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronised reset
    input wire logic pin, // Raw brake pin
    input wire logic rising_sel, // 1 selects rising edge
    output logic edge_seen // One-cycle pulse
);
    logic sync1;
    logic sync2;
    logic last;
    logic next_edge_seen;

    always_comb begin
        if (rising_sel) begin
            next_edge_seen = sync2 & ~last;
        end else begin
            next_edge_seen = ~sync2 & last;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Pin idles high; reset to that level so release sees no false edge
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            last <= 1'b1;
            edge_seen <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            last <= sync2;
            edge_seen <= next_edge_seen;
        end
    end
endmodule

// [hw/pwm_output_brake_stage.sv]
`timescale 1ns/1ps
`include "pwm_brake_defines.svh"

// Function
// - With brake input enabled, a brake-pin edge of the chosen polarity sets the brake flag.
// - Only reset or a software write of 0 clears the brake flag; no other logic does.
// - The edge select bit picks falling (0) or rising (1) brake edges.
// - While braking each channel is replaced by its brake output level bit.
// - Each channel's invert bit passes the signal straight (0) or inverted (1).
// - Interrupt type 00 falling, 01 rising, 10 period centre, 11 period end.
// - Centre and end interrupts fire only in centre-aligned mode.
// - Channel select 000 to 101 picks channel 0 to 5, other codes pick channel 0.
// - Mask enable 0 passes the generated signal, 1 substitutes the mask level.
// - A masked channel takes its mask level bit, low for 0 and high for 1, before the invert bit.
module pwm_output_brake_stage
    import pwm_brake_pkg::*;
#(
    parameter int CHANNELS = 6
) (
    input wire logic clock, // 25 MHz system clock
    input wire logic nrst, // Async active-low reset
    input pwm_brake_pkg::wb_req_t wb_req, // Wishbone request
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input pwm_brake_pkg::pwm_events_t events, // Generator waveforms and period events
    input wire logic brake_input_pin, // Fault brake pin
    output logic [CHANNELS-1:0] pwm_out, // Channel output pins
    output logic pwm_irq, // PWM interrupt pulse
    output logic pwm_run_a // Run bit to the counter
);
    logic rst_sync1;
    logic rst_n;
    logic [7:0] irq_control;
    logic [7:0] output_polarity;
    logic [7:0] brake_control_data;
    logic [7:0] pwm_control;
    logic [7:0] output_mask_enable;
    logic [7:0] output_mask_level;
    logic brake_active;
    logic brake_edge;
    logic [CHANNELS-1:0] wave_last;
    logic [7:0] next_irq_control;
    logic [7:0] next_output_polarity;
    logic [7:0] next_brake_control_data;
    logic [7:0] next_pwm_control;
    logic [7:0] next_output_mask_enable;
    logic [7:0] next_output_mask_level;
    logic next_brake_active;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;
    logic [CHANNELS-1:0] next_pwm_out;
    logic next_pwm_irq;
    logic [CHANNELS-1:0] masked;
    logic [CHANNELS-1:0] braked;
    logic [2:0] chan;
    logic wr;
    logic run_set;
    irq_type_t irq_type;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    brake_edge_detect u_edge (
        .clock(clock),
        .rst_n(rst_n),
        .pin(brake_input_pin),
        .rising_sel(brake_control_data[`BRAKE_EDGE_SELECT_BIT]),
        .edge_seen(brake_edge)
    );

    // Register file
    always_comb begin
        wr = wb_req.cyc & wb_req.stb & wb_req.we & ~wb_ack_o & wb_req.sel[0];
        next_irq_control = irq_control;
        next_output_polarity = output_polarity;
        next_brake_control_data = brake_control_data;
        next_pwm_control = pwm_control;
        next_output_mask_enable = output_mask_enable;
        next_output_mask_level = output_mask_level;
        run_set = 1'b0;
        if (wr) begin
            unique case (wb_req.adr)
                `IRQ_CONTROL_ADDR: next_irq_control = wb_req.dat[7:0] & 8'h37;
                `OUTPUT_POLARITY_ADDR: next_output_polarity = wb_req.dat[7:0] & 8'h3f;
                `BRAKE_CONTROL_DATA_ADDR: next_brake_control_data = wb_req.dat[7:0];
                `PWM_CONTROL_ADDR: begin
                    next_pwm_control = wb_req.dat[7:0] & 8'h07;
                    run_set = wb_req.dat[`PWM_RUN_BIT];
                end
                `MASK_ENABLE_ADDR: next_output_mask_enable = wb_req.dat[7:0] & 8'h3f;
                `MASK_LEVEL_ADDR: next_output_mask_level = wb_req.dat[7:0] & 8'h3f;
                default: ;
            endcase
        end
        // Software may only clear the flag; a write of 1 keeps the old value
        next_brake_control_data[`BRAKE_FLAG_BIT] =
            (wr && wb_req.adr == `BRAKE_CONTROL_DATA_ADDR) ?
            (brake_control_data[`BRAKE_FLAG_BIT] & wb_req.dat[`BRAKE_FLAG_BIT]) :
            brake_control_data[`BRAKE_FLAG_BIT];
        if (brake_edge && pwm_control[`BRAKE_INPUT_ENABLE_BIT]) begin
            next_brake_control_data[`BRAKE_FLAG_BIT] = 1'b1;
        end
        // Brake held until run is set with the flag clear; a set flag or new edge wins over release
        next_brake_active = brake_active;
        if (run_set) begin
            next_brake_active = 1'b0;
        end
        if (next_brake_control_data[`BRAKE_FLAG_BIT]) begin
            next_brake_active = 1'b1;
        end
        // Braking stops the counter until software restarts it
        if (brake_edge && pwm_control[`BRAKE_INPUT_ENABLE_BIT]) begin
            next_pwm_control[`PWM_RUN_BIT] = 1'b0;
        end
    end

    // Bus answer, one cycle after the request
    always_comb begin
        next_wb_ack_o = wb_req.cyc & wb_req.stb & ~wb_ack_o;
        next_wb_dat_o = 32'h0000_0000;
        if (wb_req.cyc && wb_req.stb && !wb_ack_o && !wb_req.we) begin
            unique case (wb_req.adr)
                `IRQ_CONTROL_ADDR: next_wb_dat_o[7:0] = irq_control;
                `OUTPUT_POLARITY_ADDR: next_wb_dat_o[7:0] = output_polarity;
                `BRAKE_CONTROL_DATA_ADDR: next_wb_dat_o[7:0] = brake_control_data;
                `PWM_CONTROL_ADDR: next_wb_dat_o[7:0] = pwm_control;
                `MASK_ENABLE_ADDR: next_wb_dat_o[7:0] = output_mask_enable;
                `MASK_LEVEL_ADDR: next_wb_dat_o[7:0] = output_mask_level;
                `BRAKE_STATUS_ADDR: next_wb_dat_o[7:0] = {7'h00, brake_active};
                default: next_wb_dat_o = 32'h0000_0000;
            endcase
        end
    end

    // Output path per channel
    generate
        for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
            always_comb begin
                masked[i] = output_mask_enable[i] ? output_mask_level[i] :
                    events.wave[i];
                braked[i] = brake_active ? brake_control_data[i] : masked[i];
                next_pwm_out[i] = braked[i] ^ output_polarity[i];
            end
        end
    endgenerate

    // Interrupt source
    always_comb begin
        irq_type = irq_type_t'(irq_control[`IRQ_TYPE_LSB +: 2]);
        chan = irq_control[`IRQ_CHANNEL_MSB:0];
        if (chan > 3'h5) begin
            chan = 3'h0;
        end
        unique case (irq_type)
            irq_falling: next_pwm_irq = wave_last[chan] & ~events.wave[chan];
            irq_rising: next_pwm_irq = ~wave_last[chan] & events.wave[chan];
            irq_centre: next_pwm_irq = events.period_centre &
                pwm_control[`CENTRE_ALIGNED_BIT];
            irq_end: next_pwm_irq = events.period_end &
                pwm_control[`CENTRE_ALIGNED_BIT];
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_control <= `REG_RESET;
            output_polarity <= `REG_RESET;
            brake_control_data <= `REG_RESET;
            pwm_control <= `REG_RESET;
            output_mask_enable <= `REG_RESET;
            output_mask_level <= `REG_RESET;
            brake_active <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            pwm_out <= '0;
            pwm_irq <= 1'b0;
            wave_last <= '0;
            pwm_run_a <= 1'b0;
        end else begin
            irq_control <= next_irq_control;
            output_polarity <= next_output_polarity;
            brake_control_data <= next_brake_control_data;
            pwm_control <= next_pwm_control;
            output_mask_enable <= next_output_mask_enable;
            output_mask_level <= next_output_mask_level;
            brake_active <= next_brake_active;
            wb_ack_o <= next_wb_ack_o;
            wb_dat_o <= next_wb_dat_o;
            pwm_out <= next_pwm_out;
            pwm_irq <= next_pwm_irq;
            wave_last <= events.wave;
            pwm_run_a <= next_pwm_control[`PWM_RUN_BIT];
        end
    end
endmodule

// [verification/pwm_brake_sva.sv]
`timescale 1ns/1ps
`include "pwm_brake_defines.svh"
module pwm_brake_sva
    import pwm_brake_pkg::*;
#(parameter int CHANNELS = 6) (
    input wire logic clock, // Clock
    input wire logic nrst, // Reset
    input pwm_brake_pkg::wb_req_t wb_req, // Request
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input pwm_brake_pkg::pwm_events_t events, // Events
    input wire logic brake_input_pin, // Brake pin
    input wire logic [CHANNELS-1:0] pwm_out, // Outputs
    input wire logic pwm_irq, // Interrupt
    input wire logic pwm_run_a // Run bit
);
    logic [7:0] sh [6];
    logic [7:0] next_sh [6];
    logic [2:0] ch;
    // Shadow of control, irq, brake, polarity, mask enable, mask level
    always_comb begin
        next_sh = sh;
        if (wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && !wb_ack_o) begin
            case (wb_req.adr)
                `PWM_CONTROL_ADDR: next_sh[0] = wb_req.dat[7:0];
                `IRQ_CONTROL_ADDR: next_sh[1] = wb_req.dat[7:0];
                `BRAKE_CONTROL_DATA_ADDR: next_sh[2] = wb_req.dat[7:0];
                `OUTPUT_POLARITY_ADDR: next_sh[3] = wb_req.dat[7:0];
                `MASK_ENABLE_ADDR: next_sh[4] = wb_req.dat[7:0];
                `MASK_LEVEL_ADDR: next_sh[5] = wb_req.dat[7:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sh <= '{default: 8'h00};
        end else begin
            sh <= next_sh;
        end
    end
    assign ch = (sh[1][2:0] > 3'h5) ? 3'h0 : sh[1][2:0];
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_ack; wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
    property p_trip;
        pwm_run_a && sh[0][1] && (sh[2][6] ? $rose(brake_input_pin) : $fell(brake_input_pin))
        |-> ##[1:6] !pwm_run_a;
    endproperty
    a_trip: assert property (p_trip) else $error("brake edge ignored");
    property p_period;
        sh[1][5] && sh[0][2] && (sh[1][4] ? events.period_end : events.period_centre) |=> pwm_irq;
    endproperty
    a_period: assert property (p_period) else $error("period irq missing");
    property p_no_period; sh[1][5] && !sh[0][2] |=> !pwm_irq; endproperty
    a_no_period: assert property (p_no_period) else $error("period irq off mode");
    property p_edge;
        !sh[1][5] && (sh[1][4] ? $rose(events.wave[ch]) : $fell(events.wave[ch]))
        |-> ##[1:2] pwm_irq;
    endproperty
    a_edge: assert property (p_edge) else $error("edge irq missing");
    property p_path;
        pwm_run_a && $past(pwm_run_a) && $stable(sh[3]) && $stable(sh[4]) && $stable(sh[5])
        |-> pwm_out == ((($past(events.wave) & ~sh[4][5:0]) | (sh[5][5:0] & sh[4][5:0]))
        ^ sh[3][5:0]);
    endproperty
    a_path: assert property (p_path) else $error("channel output wrong");
    c_trip: cover property ($fell(pwm_run_a));
    c_irq: cover property (pwm_irq);
    c_mask: cover property (sh[4] != 8'h00 && pwm_run_a);
endmodule

bind pwm_output_brake_stage pwm_brake_sva #(.CHANNELS(CHANNELS)) checker_inst (
    .clock(clock), .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .events(events), .brake_input_pin(brake_input_pin), .pwm_out(pwm_out),
    .pwm_irq(pwm_irq), .pwm_run_a(pwm_run_a)
);

// [verification/fault_sensor_model.sv]
`timescale 1ns/1ps
module fault_sensor_model (
    input wire logic fault_active, // Fault present
    output logic brake_input_pin // Pulled up, low on fault
);
    assign brake_input_pin = !fault_active;
endmodule

// [verification/tb_pwm_output_brake_stage.sv]
`timescale 1ns/1ps
module tb_pwm_output_brake_stage;
    import pwm_brake_pkg::*;
    typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] r;} row_t;
    localparam row_t ROWS [8] = '{'{10'h2dc, 8'hff, 8'h37}, '{10'h358, 8'hff, 8'h3f},
        '{10'h35c, 8'hff, 8'h7f}, '{10'h380, 8'h06, 8'h06}, '{10'h384, 8'hff, 8'h3f},
        '{10'h388, 8'hff, 8'h3f}, '{10'h38c, 8'hff, 8'h00}, '{10'h3fc, 8'hff, 8'h00}};
    localparam logic [5:0] POL = 6'h06;
    localparam logic [5:0] MEN = 6'h30;
    localparam logic [5:0] MLV = 6'h10;
    logic clock, nrst, wb_ack_o, pwm_irq, pwm_run_a, fault_active, brake_input_pin;
    logic [31:0] wb_dat_o;
    logic [5:0] pwm_out;
    logic [7:0] q;
    logic [1:0] typ;
    wb_req_t req;
    pwm_events_t ev;
    int miscompares, samples_checked, n;
    pwm_output_brake_stage #(.CHANNELS(6)) DUT (.clock(clock), .nrst(nrst), .wb_req(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .events(ev), .brake_input_pin(brake_input_pin),
        .pwm_out(pwm_out), .pwm_irq(pwm_irq), .pwm_run_a(pwm_run_a));
    fault_sensor_model sensor (.fault_active(fault_active), .brake_input_pin(brake_input_pin));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] r);
        int k;
        @(posedge clock);
        req <= '{adr: a, dat: {24'h0, d}, we: w, sel: 4'hf, cyc: 1'b1, stb: 1'b1};
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        r = wb_dat_o[7:0];
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        if (k >= 20) chk(8'h01, 8'h00);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] r;
        wb(a, 1'b0, 8'h00, r);
        chk(r, e);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        #(40 * 3000);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        nrst = 1'b0;
        req = '0;
        ev = '0;
        fault_active = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (ROWS[i]) begin
            rd(ROWS[i].a, 8'h00);
            wb(ROWS[i].a, 1'b1, ROWS[i].w, q);
            rd(ROWS[i].a, ROWS[i].r);
        end
        wb(10'h358, 1'b1, {2'b00, POL}, q);
        wb(10'h384, 1'b1, {2'b00, MEN}, q);
        wb(10'h388, 1'b1, {2'b00, MLV}, q);
        wb(10'h35c, 1'b1, 8'h2a, q);
        wb(10'h380, 1'b1, 8'h07, q);
        ev.wave <= 6'h0f;
        repeat (3) @(posedge clock);
        chk({2'b00, pwm_out}, {2'b00, ((6'h0f & ~MEN) | (MLV & MEN)) ^ POL});
        // Types 0..3 with channel code 6, then period end outside centre mode
        for (int t = 0; t < 5; t++) begin
            typ = (t == 4) ? 2'd3 : t[1:0];
            ev.wave <= (t == 0) ? 6'h3f : 6'h00;
            repeat (2) @(posedge clock);
            if (t == 4) wb(10'h380, 1'b1, 8'h03, q);
            wb(10'h2dc, 1'b1, {2'b00, typ, 4'h6}, q);
            if (t < 2) ev.wave <= ~ev.wave;
            ev.period_centre <= (t == 2);
            ev.period_end <= (t > 2);
            @(posedge clock);
            ev.period_centre <= 1'b0;
            ev.period_end <= 1'b0;
            n = 0;
            repeat (4) begin
                @(posedge clock);
                n += pwm_irq;
            end
            chk(n[7:0], (t < 4) ? 8'h01 : 8'h00);
        end
        fault_active <= 1'b1;
        repeat (8) @(posedge clock);
        chk({7'h0, pwm_run_a}, 8'h00);
        chk({2'b00, pwm_out}, {2'b00, 6'h2a ^ POL});
        rd(10'h35c, 8'haa);
        fault_active <= 1'b0;
        wb(10'h35c, 1'b1, 8'haa, q);
        repeat (8) @(posedge clock);
        rd(10'h35c, 8'haa);
        wb(10'h35c, 1'b1, 8'h2a, q);
        rd(10'h35c, 8'h2a);
        chk({2'b00, pwm_out}, {2'b00, 6'h2a ^ POL});
        wb(10'h380, 1'b1, 8'h03, q);
        repeat (3) @(posedge clock);
        chk({2'b00, pwm_out}, {2'b00, (MLV & MEN) ^ POL});
        wb(10'h35c, 1'b1, 8'h6a, q);
        fault_active <= 1'b1;
        repeat (8) @(posedge clock);
        chk({7'h0, pwm_run_a}, 8'h01);
        fault_active <= 1'b0;
        repeat (8) @(posedge clock);
        chk({7'h0, pwm_run_a}, 8'h00);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        chk({1'b0, pwm_run_a, pwm_out}, 8'h00);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd(10'h35c, 8'h00);
        tally_and_finish;
    end
endmodule
